//--- src/lcr_pkg.sv
// lane configuration register constants: offsets, field positions, resets
// assumes a 32-bit classic wishbone slave reaching word-aligned registers
//
// Notes on behaviour
// - bits 15..12 of each lane register read zero; writes there are dropped
// - bit 11 lane clock compensation, reset 0, ORed with global bit 11
// - bits 10..9 pick multi pin: io standard, comma, loss, prbs pass
// - lane a: code 10 shows status bit 0, code 11 status bit 4
// - lane b: code 10 shows status bit 1, code 11 status bit 5
// - select in effect is lane select ORed with global select
// - bit 8 loss detect, reset 1, ANDed with global detect enable
// - bits 7,6 configuration, reset 0, each ORed with global bit
// - configuration bit writable only while its configuration pin is low
// - bits 5,4 preemphasis, reset 0, each ORed with global bit
// - bit 3 loopback, reset 0, ORed with main control bit 14
// - lane a loopback bit writable only while loopback pin is low
// - bit 2 prbs enable, reset 0, ORed with global prbs bit
// - prbs bit writable only while prbs enable pin is low
// - bit 1 comma detect, reset 1, ANDed with sync pin and global bit
// - bit 0 power down, reset 0, ORed with main control bit 11
package lcr_pkg;

	// register indices; byte address is four times the index
	localparam logic [5:0]  LANE_A_IDX   = 6'h10;
	localparam logic [5:0]  LANE_B_IDX   = 6'h11;

	// field positions inside a lane or global register
	localparam int          CTC_BIT      = 11;
	localparam int          MF_HI_BIT    = 10;
	localparam int          MF_LO_BIT    = 9;
	localparam int          LOS_EN_BIT   = 8;
	localparam int          CFG_HI_BIT   = 7;
	localparam int          CFG_LO_BIT   = 6;
	localparam int          PRE_HI_BIT   = 5;
	localparam int          PRE_LO_BIT   = 4;
	localparam int          LOOP_BIT     = 3;
	localparam int          PRBS_BIT     = 2;
	localparam int          COMMA_BIT    = 1;
	localparam int          PDN_BIT      = 0;

	// main control register bits that reach every lane
	localparam int          MAIN_LOOP_BIT = 14;
	localparam int          MAIN_PDN_BIT  = 11;

	// status register bit positions per lane
	localparam int          LOS_A_STAT   = 0;
	localparam int          LOS_B_STAT   = 1;
	localparam int          PRBS_A_STAT  = 4;
	localparam int          PRBS_B_STAT  = 5;

	// reset value and bits that software can store
	localparam logic [15:0] LANE_RESET   = 16'h0102;
	localparam logic [15:0] LANE_WMASK   = 16'h0FFF;

	// multifunction pin select codes
	localparam logic [1:0]  MF_IO_STD    = 2'h0;
	localparam logic [1:0]  MF_COMMA     = 2'h1;
	localparam logic [1:0]  MF_LOS       = 2'h2;
	localparam logic [1:0]  MF_PRBS      = 2'h3;

	// synchroniser depth for pins
	localparam int          SYNC_STAGES  = 2;

endpackage

//--- src/lcr_lane.sv
// one lane configuration register and its effective controls
// assumes pins arrive already synchronised and globals on clk_sys
module lcr_lane
	import lcr_pkg::*;
#(
	parameter int LOS_STAT  = 0,
	parameter int PRBS_STAT = 4,
	parameter bit HAS_LOOP_LOCK = 1'b0
) (
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic        wr_en,
	input  wire logic [1:0]  wr_bytes,
	input  wire logic [15:0] wr_data,
	input  wire logic [15:0] glb_cfg,
	input  wire logic [15:0] main_ctrl,
	input  wire logic [7:0]  status_bits,
	input  wire logic        comma_seen,
	input  wire logic        io_std_hstl,
	input  wire logic        cfg_lock_low,
	input  wire logic        cfg_lock_high,
	input  wire logic        prbs_lock,
	input  wire logic        loop_lock,
	input  wire logic        sync_en,
	output logic      [15:0] cfg_value,
	output logic             ctc_en,
	output logic             los_det_en,
	output logic      [1:0]  cfg_eff,
	output logic      [1:0]  preemph,
	output logic             loopback,
	output logic             prbs_en,
	output logic             comma_en,
	output logic             power_down,
	output logic             multi_pin
);

	logic [15:0] lock_mask;
	logic [15:0] wmask;
	logic [1:0]  mf_sel;
	logic        next_multi;

	// bits frozen by a high pin, then byte lanes and storable bits
	always_comb begin
		lock_mask = 16'h0000;
		lock_mask[CFG_LO_BIT] = cfg_lock_low;
		lock_mask[CFG_HI_BIT] = cfg_lock_high;
		lock_mask[PRBS_BIT] = prbs_lock;
		lock_mask[LOOP_BIT] = HAS_LOOP_LOCK & loop_lock;
		wmask = {{8{wr_bytes[1]}}, {8{wr_bytes[0]}}}
			& LANE_WMASK & ~lock_mask;
	end

	// stored register; unwritable bits keep their value
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cfg_value <= LANE_RESET;
		end else if (wr_en) begin
			cfg_value <= (cfg_value & ~wmask) | (wr_data & wmask);
		end
	end

	// effective controls follow their inputs without delay
	assign ctc_en     = cfg_value[CTC_BIT] | glb_cfg[CTC_BIT];
	assign los_det_en = cfg_value[LOS_EN_BIT] & glb_cfg[LOS_EN_BIT];
	assign cfg_eff    = cfg_value[CFG_HI_BIT:CFG_LO_BIT]
		| glb_cfg[CFG_HI_BIT:CFG_LO_BIT];
	assign preemph    = cfg_value[PRE_HI_BIT:PRE_LO_BIT]
		| glb_cfg[PRE_HI_BIT:PRE_LO_BIT];
	assign loopback   = cfg_value[LOOP_BIT] | main_ctrl[MAIN_LOOP_BIT];
	assign prbs_en    = cfg_value[PRBS_BIT] | glb_cfg[PRBS_BIT];
	assign comma_en   = cfg_value[COMMA_BIT] & sync_en
		& glb_cfg[COMMA_BIT];
	assign power_down = cfg_value[PDN_BIT] | main_ctrl[MAIN_PDN_BIT];
	assign mf_sel     = cfg_value[MF_HI_BIT:MF_LO_BIT]
		| glb_cfg[MF_HI_BIT:MF_LO_BIT];

	// multifunction source selection
	always_comb begin
		unique case (mf_sel)
			MF_IO_STD: next_multi = io_std_hstl;
			MF_COMMA:  next_multi = comma_seen;
			MF_LOS:    next_multi = status_bits[LOS_STAT];
			MF_PRBS:   next_multi = status_bits[PRBS_STAT];
		endcase
	end

	// pin is driven from a flop
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			multi_pin <= 1'b0;
		end else begin
			multi_pin <= next_multi;
		end
	end

endmodule

//--- src/lcr_top.sv
// lane configuration register bank for the first two lanes
// assumes a classic wishbone master on clk_sys; global and main control
// values and status come from logic on clk_sys; pins are asynchronous
//
// Our own choice: register access over Wishbone.
module lcr_top
	import lcr_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// values from the rest of the device on clk_sys
	input  wire logic [15:0] glb_cfg,
	input  wire logic [15:0] main_ctrl,
	input  wire logic [7:0]  status_bits,
	input  wire logic        lane_a_comma_seen,
	input  wire logic        lane_b_comma_seen,
	// asynchronous pins
	input  wire logic        cfg_pin_low,
	input  wire logic        cfg_pin_high,
	input  wire logic        prbs_enable_pin,
	input  wire logic        sync_enable_pin,
	input  wire logic        lane_a_loopback_pin,
	input  wire logic        io_std_pin,
	// multifunction pins
	output logic             lane_a_multi_pin,
	output logic             lane_b_multi_pin,
	// lane a effective controls
	output logic             lane_a_ctc_en,
	output logic             lane_a_los_det_en,
	output logic      [1:0]  lane_a_cfg,
	output logic      [1:0]  lane_a_preemph,
	output logic             lane_a_loopback,
	output logic             lane_a_prbs_en,
	output logic             lane_a_comma_en,
	output logic             lane_a_power_down,
	// lane b effective controls
	output logic             lane_b_ctc_en,
	output logic             lane_b_los_det_en,
	output logic      [1:0]  lane_b_cfg,
	output logic      [1:0]  lane_b_preemph,
	output logic             lane_b_loopback,
	output logic             lane_b_prbs_en,
	output logic             lane_b_comma_en,
	output logic             lane_b_power_down
);

	// pin vector order: cfg low, cfg high, prbs, sync, loop a, io std
	localparam int NPINS = 6;

	logic [NPINS-1:0] pin_raw;
	logic [NPINS-1:0] pin_meta;
	logic [NPINS-1:0] pin_sync;
	logic             cfg_low_s;
	logic             cfg_high_s;
	logic             prbs_pin_s;
	logic             sync_pin_s;
	logic             loop_a_pin_s;
	logic             io_std_s;

	logic             req;
	logic             take;
	logic [5:0]       word_idx;
	logic             hit_a;
	logic             hit_b;
	logic             wr_a;
	logic             wr_b;
	logic [31:0]      next_rdata;
	logic [15:0]      lane_a_value;
	logic [15:0]      lane_b_value;

	// gather the asynchronous pins
	assign pin_raw = {io_std_pin, lane_a_loopback_pin, sync_enable_pin,
		prbs_enable_pin, cfg_pin_high, cfg_pin_low};

	// two-flop synchronisers; only the second stage is read by logic
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
		end
	end

	// named views of synchronised pins
	assign cfg_low_s    = pin_sync[0];
	assign cfg_high_s   = pin_sync[1];
	assign prbs_pin_s   = pin_sync[2];
	assign sync_pin_s   = pin_sync[3];
	assign loop_a_pin_s = pin_sync[4];
	assign io_std_s     = pin_sync[5];

	// bus request decode; a request is taken once, when ack rises
	assign req      = wb_cyc_i & wb_stb_i;
	assign take     = req & ~wb_ack_o;
	assign word_idx = wb_adr_i[7:2];
	assign hit_a    = (word_idx == LANE_A_IDX);
	assign hit_b    = (word_idx == LANE_B_IDX);
	assign wr_a     = take & wb_we_i & hit_a;
	assign wr_b     = take & wb_we_i & hit_b;

	// one acknowledge per request, dropped in the following cycle
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= take;
		end
	end

	// read mux; unmapped words and upper bits read zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (hit_a) begin
			next_rdata[15:0] = lane_a_value;
		end else if (hit_b) begin
			next_rdata[15:0] = lane_b_value;
		end
	end

	// read data captured with the acknowledge and held afterwards
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (take & ~wb_we_i) begin
			wb_dat_o <= next_rdata;
		end
	end

	// first lane: its loopback bit can be frozen by its pin
	lcr_lane #(
		.LOS_STAT      (LOS_A_STAT),
		.PRBS_STAT     (PRBS_A_STAT),
		.HAS_LOOP_LOCK (1'b1)
	) u_lane_a (
		.clk_sys       (clk_sys),
		.resetn        (resetn),
		.wr_en         (wr_a),
		.wr_bytes      (wb_sel_i[1:0]),
		.wr_data       (wb_dat_i[15:0]),
		.glb_cfg       (glb_cfg),
		.main_ctrl     (main_ctrl),
		.status_bits   (status_bits),
		.comma_seen    (lane_a_comma_seen),
		.io_std_hstl   (io_std_s),
		.cfg_lock_low  (cfg_low_s),
		.cfg_lock_high (cfg_high_s),
		.prbs_lock     (prbs_pin_s),
		.loop_lock     (loop_a_pin_s),
		.sync_en       (sync_pin_s),
		.cfg_value     (lane_a_value),
		.ctc_en        (lane_a_ctc_en),
		.los_det_en    (lane_a_los_det_en),
		.cfg_eff       (lane_a_cfg),
		.preemph       (lane_a_preemph),
		.loopback      (lane_a_loopback),
		.prbs_en       (lane_a_prbs_en),
		.comma_en      (lane_a_comma_en),
		.power_down    (lane_a_power_down),
		.multi_pin     (lane_a_multi_pin)
	);

	// second lane: loopback bit always writable
	lcr_lane #(
		.LOS_STAT      (LOS_B_STAT),
		.PRBS_STAT     (PRBS_B_STAT),
		.HAS_LOOP_LOCK (1'b0)
	) u_lane_b (
		.clk_sys       (clk_sys),
		.resetn        (resetn),
		.wr_en         (wr_b),
		.wr_bytes      (wb_sel_i[1:0]),
		.wr_data       (wb_dat_i[15:0]),
		.glb_cfg       (glb_cfg),
		.main_ctrl     (main_ctrl),
		.status_bits   (status_bits),
		.comma_seen    (lane_b_comma_seen),
		.io_std_hstl   (io_std_s),
		.cfg_lock_low  (cfg_low_s),
		.cfg_lock_high (cfg_high_s),
		.prbs_lock     (prbs_pin_s),
		.loop_lock     (1'b0),
		.sync_en       (sync_pin_s),
		.cfg_value     (lane_b_value),
		.ctc_en        (lane_b_ctc_en),
		.los_det_en    (lane_b_los_det_en),
		.cfg_eff       (lane_b_cfg),
		.preemph       (lane_b_preemph),
		.loopback      (lane_b_loopback),
		.prbs_en       (lane_b_prbs_en),
		.comma_en      (lane_b_comma_en),
		.power_down    (lane_b_power_down),
		.multi_pin     (lane_b_multi_pin)
	);

endmodule

//--- bench/lcr_monitor.sv
// checker for the lane configuration register bank top ports
// assumes it is bound into lcr_top; one clock, async active low reset
module lcr_monitor (
	input wire logic        clk_sys,
	input wire logic        resetn,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic [15:0] glb_cfg,
	input wire logic [15:0] main_ctrl,
	input wire logic [7:0]  status_bits,
	input wire logic        lane_a_multi_pin,
	input wire logic        lane_b_multi_pin,
	input wire logic        lane_a_ctc_en,
	input wire logic        lane_a_los_det_en,
	input wire logic [1:0]  lane_a_cfg,
	input wire logic        lane_a_loopback,
	input wire logic        lane_a_comma_en,
	input wire logic        lane_a_power_down,
	input wire logic        lane_b_power_down
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// a request waiting for its answer
	sequence req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// global select forces the prbs pass code; the release edge is left
	// out because the flops still load their reset value there
	sequence mf_prbs_s;
		resetn && glb_cfg[10:9] == 2'h3;
	endsequence
	ack_answer_a: assert property (req_s |=> wb_ack_o)
		else $error("no ack one cycle after a request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:12] == '0)
		else $error("read data upper bits not zero");
	ctc_or_a: assert property (glb_cfg[11] |-> lane_a_ctc_en)
		else $error("compensation not forced by global bit");
	los_and_a: assert property (!glb_cfg[8] |-> !lane_a_los_det_en)
		else $error("loss detect on without global enable");
	cfg_or_a: assert property (
		(lane_a_cfg & glb_cfg[7:6]) == glb_cfg[7:6])
		else $error("configuration not forced by global bits");
	comma_and_a: assert property (!glb_cfg[1] |-> !lane_a_comma_en)
		else $error("comma detect on without global bit");
	loop_or_a: assert property (main_ctrl[14] |-> lane_a_loopback)
		else $error("loopback not forced by main control");
	pdn_or_a: assert property (main_ctrl[11] |->
		lane_a_power_down && lane_b_power_down)
		else $error("power down not forced by main control");
	mf_prbs_a: assert property (mf_prbs_s |=>
		lane_a_multi_pin == $past(status_bits[4]) &&
		lane_b_multi_pin == $past(status_bits[5]))
		else $error("multi pin does not show prbs pass");
endmodule

bind lcr_top lcr_monitor lcr_monitor_i (.*);

//--- bench/lcr_top_test.sv
// self-checking bench for the lane configuration register bank
// assumes lcr_top and its package; bench acts as wishbone master
module lcr_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	import lcr_pkg::*;
	logic clk_sys = 1'b0, resetn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0, wb_ack_o, lane_a_multi_pin, lane_b_multi_pin;
	logic [7:0] wb_adr_i = 8'h00, status_bits = 8'h00;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, lfsr = 32'hE2E3;
	logic [3:0] wb_sel_i = 4'h0;
	logic [15:0] glb_cfg = 16'h0, main_ctrl = 16'h0, reg_a, reg_b;
	logic lane_a_comma_seen = 1'b0, lane_b_comma_seen = 1'b0;
	logic cfg_pin_low = 1'b0, cfg_pin_high = 1'b0, prbs_enable_pin = 1'b0;
	logic sync_enable_pin = 1'b1, lane_a_loopback_pin = 1'b0;
	logic io_std_pin = 1'b0;
	logic lane_a_ctc_en, lane_a_los_det_en, lane_a_loopback, lane_a_prbs_en;
	logic lane_a_comma_en, lane_a_power_down, lane_b_ctc_en;
	logic lane_b_los_det_en, lane_b_loopback, lane_b_prbs_en;
	logic lane_b_comma_en, lane_b_power_down;
	logic [1:0] lane_a_cfg, lane_a_preemph, lane_b_cfg, lane_b_preemph;
	logic [31:0] exp_q[$];
	int n_mismatch = 0, num_checks = 0, cyc_cnt = 0;
	wire [9:0] eff_a = {lane_a_ctc_en, lane_a_los_det_en, lane_a_cfg,
		lane_a_preemph, lane_a_loopback, lane_a_prbs_en, lane_a_comma_en,
		lane_a_power_down};
	wire [9:0] eff_b = {lane_b_ctc_en, lane_b_los_det_en, lane_b_cfg,
		lane_b_preemph, lane_b_loopback, lane_b_prbs_en, lane_b_comma_en,
		lane_b_power_down};

	lcr_top lcr_top_i (.*);

	// clock and hang guard
	always #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			n_mismatch++;
			close_out();
		end
	end
	// read answers compared with the oldest note
	always @(posedge clk_sys) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
			chk(wb_dat_o, exp_q.pop_front());
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic rnd();
		repeat (9) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
	endtask
	// one classic cycle, held until ack is sampled
	task automatic bus(input logic [7:0] a, input logic w,
		input logic [15:0] d, input logic [3:0] s);
		@(posedge clk_sys);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
		{wb_adr_i, wb_dat_i, wb_sel_i} <= {a, 16'h0, d, s};
		do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask
	// write with the bench copy following byte lanes and lock pins
	task automatic wr(input logic [7:0] a, input logic [15:0] d,
		input logic [3:0] s);
		logic [15:0] m;
		m = {{8{s[1]}}, {8{s[0]}}} & 16'h0FFF & ~{8'h0, cfg_pin_high,
			cfg_pin_low, 2'b0, lane_a_loopback_pin & a == 8'h40,
			prbs_enable_pin, 2'b0};
		if (a == 8'h40)
			reg_a = (reg_a & ~m) | (d & m);
		if (a == 8'h44)
			reg_b = (reg_b & ~m) | (d & m);
		bus(a, 1'b1, d, s);
	endtask
	task automatic rd(input logic [7:0] a);
		exp_q.push_back(a == 8'h40 ? {16'h0, reg_a} :
			a == 8'h44 ? {16'h0, reg_b} : 32'h0);
		bus(a, 1'b0, 16'h0, 4'hF);
	endtask
	function automatic logic [9:0] eff(input logic [15:0] r);
		return {r[11] | glb_cfg[11], r[8] & glb_cfg[8],
			r[7:6] | glb_cfg[7:6], r[5:4] | glb_cfg[5:4],
			r[3] | main_ctrl[14], r[2] | glb_cfg[2],
			r[1] & sync_enable_pin & glb_cfg[1], r[0] | main_ctrl[11]};
	endfunction
	function automatic logic mf(input logic [15:0] r, input logic [2:0] src);
		case (r[10:9] | glb_cfg[10:9])
			2'h0: return io_std_pin;
			2'h1: return src[0];
			2'h2: return src[1];
			default: return src[2];
		endcase
	endfunction

	// main sequence: reset values, random traffic with locks, unmapped
	initial begin
		reg_a = 16'h0102;
		reg_b = 16'h0102;
		repeat (4) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(8'h40);
		rd(8'h44);
		for (int i = 0; i < 24; i++) begin
			rnd();
			{cfg_pin_low, cfg_pin_high, prbs_enable_pin} <= lfsr[2:0];
			{sync_enable_pin, lane_a_loopback_pin, io_std_pin} <= lfsr[5:3];
			{lane_a_comma_seen, lane_b_comma_seen} <= lfsr[7:6];
			status_bits <= lfsr[15:8];
			glb_cfg <= lfsr[31:16] & 16'h0FFF;
			rnd();
			main_ctrl <= lfsr[15:0];
			repeat (4) @(posedge clk_sys);
			wr(8'h40, lfsr[31:16], {2'b00, lfsr[1:0] | 2'b01});
			rnd();
			wr(8'h44, lfsr[15:0] | 16'hF000, lfsr[3:0]);
			rd(8'h40);
			rd(8'h44);
			chk({22'h0, eff_a}, {22'h0, eff(reg_a)});
			chk({22'h0, eff_b}, {22'h0, eff(reg_b)});
			chk({31'h0, lane_a_multi_pin}, {31'h0, mf(reg_a,
				{status_bits[4], status_bits[0], lane_a_comma_seen})});
			chk({31'h0, lane_b_multi_pin}, {31'h0, mf(reg_b,
				{status_bits[5], status_bits[1], lane_b_comma_seen})});
		end
		// second reset after traffic: registers must return to reset values
		resetn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		reg_a = 16'h0102;
		reg_b = 16'h0102;
		rd(8'h40);
		rd(8'h44);
		chk({22'h0, eff_a}, {22'h0, eff(reg_a)});
		chk({22'h0, eff_b}, {22'h0, eff(reg_b)});
		wr(8'h48, 16'hFFFF, 4'hF);
		rd(8'h48);
		rd(8'h40);
		repeat (3) @(posedge clk_sys);
		close_out();
	end
endmodule
